// ### rtl/access_sequencer.sv
// grant driven phase sequencer for one processor access on the dma bus
`timescale 1ns/1ns
module access_sequencer
  import stretcher_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // arbiter grant
  input wire logic cpu_grant_active,
  // phases
  output logic addr_select_phase,
  output logic strobe_phase,
  output logic stretch_stop
);
  logic [SEQ_CNT_W-1:0] cnt;
  logic [SEQ_CNT_W-1:0] next_cnt;
  logic next_addr;
  logic next_strobe;
  logic next_stop;

  // counts input clocks from the address phase; grant low clears all
  always_comb
  begin
    next_cnt = cnt;
    next_addr = addr_select_phase;
    next_strobe = strobe_phase;
    next_stop = stretch_stop;
    if (!cpu_grant_active)
    begin
      next_cnt = '0;
      next_addr = 1'b0;
      next_strobe = 1'b0;
      next_stop = 1'b0;
    end
    else if (!addr_select_phase)
      next_addr = 1'b1;
    else if (!strobe_phase)
    begin
      next_cnt = cnt + 1'b1;
      if (cnt == SEQ_CNT_W'(ADDR_TO_STROBE - 1))
      begin
        next_strobe = 1'b1;
        next_cnt = '0;
      end
    end
    else if (!stretch_stop)
    begin
      next_cnt = cnt + 1'b1;
      if (cnt == SEQ_CNT_W'(STROBE_TO_STOP - 1))
        next_stop = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cnt <= '0;
      addr_select_phase <= 1'b0;
      strobe_phase <= 1'b0;
      stretch_stop <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      addr_select_phase <= next_addr;
      strobe_phase <= next_strobe;
      stretch_stop <= next_stop;
    end
  end
endmodule

// ### rtl/cpu_clock_gen.sv
// quadrature processor clock generator with stretch on dma bus access
`timescale 1ns/1ns
module cpu_clock_gen
  import stretcher_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // access control
  input wire logic dma_access,
  input wire logic stretch_stop,
  // generated outputs
  output logic cpu_clk_a,
  output logic cpu_clk_b,
  output logic cpu_bus_request_n,
  output logic a_fall
);
  clk_state_t state;
  clk_state_t next_state;
  logic next_a;
  logic next_b;
  logic next_req_n;
  logic next_a_fall;

  // next state and registered clock levels
  always_comb
  begin
    next_state = state;
    case (state)
      CK_S0: next_state = CK_S1;
      CK_S1: next_state = CK_S2;
      // address and selects are settled with both clocks high
      CK_S2:
      begin
        if (!dma_access)
          next_state = CK_S3;
        else if (!stretch_stop)
          next_state = CK_S3;
      end
      CK_S3:
      begin
        if (dma_access)
          next_state = CK_STRETCH;
        else
          next_state = CK_S0;
      end
      CK_STRETCH:
      begin
        if (stretch_stop)
          next_state = CK_S0;
      end
      default: next_state = CK_S0;
    endcase
    next_a = (next_state == CK_S2) || (next_state == CK_S3) || (next_state == CK_STRETCH);
    next_b = (next_state == CK_S1) || (next_state == CK_S2);
    next_req_n = (next_state != CK_STRETCH);
    next_a_fall = (next_state == CK_S0) && (state != CK_S0);
  end

  // high in the last a-high cycle, while that cycle's address and data still stand;
  // a registered copy would land in the next processor cycle
  assign a_fall = next_a_fall;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state <= CK_S0;
      cpu_clk_a <= 1'b0;
      cpu_clk_b <= 1'b0;
      cpu_bus_request_n <= 1'b1;
    end
    else
    begin
      state <= next_state;
      cpu_clk_a <= next_a;
      cpu_clk_b <= next_b;
      cpu_bus_request_n <= next_req_n;
    end
  end
endmodule

// ### rtl/cpu_dma_bus_access_stretcher.sv
// processor to dma bus bridge: clock stretch, strobes, selects and lane steering
`timescale 1ns/1ns
module cpu_dma_bus_access_stretcher
  import stretcher_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // processor side
  input wire stretcher_pkg::cpu_access_t cpu,
  output logic cpu_clk_a,
  output logic cpu_clk_b,
  output logic [stretcher_pkg::BYTE_W-1:0] cpu_rdata,
  output logic cpu_rdata_oe,
  // dma bus arbiter
  output logic cpu_bus_request_n,
  input wire logic cpu_grant_active,
  input wire logic local_dma_active,
  input wire logic remote_dma_active,
  input wire logic remote_upper_sel,
  // dma bus
  output logic [stretcher_pkg::BUF_ADDR_W-1:0] dma_addr,
  output logic dma_addr_oe,
  input wire logic [stretcher_pkg::DMA_DATA_W-1:0] dma_data_in,
  output logic [stretcher_pkg::DMA_DATA_W-1:0] dma_data_out,
  output logic [1:0] dma_data_oe,
  output logic dma_read_strobe_n,
  output logic dma_write_strobe_n,
  output logic cs_host_if_n,
  output logic cs_buf_lo_n,
  output logic cs_buf_hi_n,
  output logic bridge_xcvr_enable_n,
  output logic upper_xcvr_enable_n,
  // drive control and status
  input wire stretcher_pkg::drive_status_t drive_status,
  output logic [stretcher_pkg::BYTE_W-1:0] ctrl_bits
);
  import stretcher_pkg::*;

  target_t target;
  logic dma_access;
  logic addr_select_phase;
  logic strobe_phase;
  logic stretch_stop;
  logic a_fall;
  logic upper_lane;
  logic stop_seen;

  logic [BYTE_W-1:0] next_ctrl;
  logic [BYTE_W-1:0] next_rdata;
  logic next_rdata_oe;
  logic [BUF_ADDR_W-1:0] next_dma_addr;
  logic next_dma_addr_oe;
  logic [DMA_DATA_W-1:0] next_dma_data;
  logic [1:0] next_dma_oe;
  logic next_rd_n;
  logic next_wr_n;
  logic next_cs_host_n;
  logic next_cs_lo_n;
  logic next_cs_hi_n;
  logic next_bridge_n;
  logic next_upper_n;
  logic next_stop_seen;
  logic [BYTE_W-1:0] status_byte;
  logic granted;

  // address decode of the current processor cycle
  assign target = decode_target(cpu.addr);
  assign dma_access = on_dma_bus(target);
  // the upper buffer is the only processor target on the high byte lane
  assign upper_lane = (target == TGT_BUF_HI);
  // our access is live only from our address phase on, while the arbiter grants and no local transfer runs
  assign granted = cpu_grant_active && addr_select_phase && !local_dma_active;

  // status byte, unused upper bits read as zero
  assign status_byte = {2'b00, drive_status};

  cpu_clock_gen u_clock_gen (
    .clk_sys(clk_sys),
    .rst(rst),
    .dma_access(dma_access),
    .stretch_stop(stretch_stop),
    .cpu_clk_a(cpu_clk_a),
    .cpu_clk_b(cpu_clk_b),
    .cpu_bus_request_n(cpu_bus_request_n),
    .a_fall(a_fall)
  );

  // the sequencer relies on the arbiter holding grant until request is released
  access_sequencer u_sequencer (
    .clk_sys(clk_sys),
    .rst(rst),
    .cpu_grant_active(cpu_grant_active),
    .addr_select_phase(addr_select_phase),
    .strobe_phase(strobe_phase),
    .stretch_stop(stretch_stop)
  );

  // control bit register: a whole byte per write, taken as the a clock falls
  always_comb
  begin
    next_ctrl = ctrl_bits;
    if (a_fall && (target == TGT_REGS) && !cpu.read && (cpu.addr[REG_SEL_BIT] == 1'b0))
      next_ctrl = cpu.wdata;
  end

  // processor read data: registers locally, dma bus byte on the strobe
  always_comb
  begin
    next_rdata = cpu_rdata;
    next_rdata_oe = 1'b0;
    next_stop_seen = stop_seen;
    if (!cpu_grant_active)
      next_stop_seen = 1'b0;
    if (cpu.read && (target == TGT_REGS))
    begin
      next_rdata_oe = cpu_clk_a;
      if (cpu.addr[REG_SEL_BIT])
        next_rdata = status_byte;
      else
        next_rdata = ctrl_bits;
    end
    else if (cpu.read && dma_access)
    begin
      next_rdata_oe = cpu_clk_a;
      // capture every strobe phase cycle until the stop is seen, so the last strobe cycle's byte stands
      if (strobe_phase && !stop_seen && granted)
      begin
        if (upper_lane)
          next_rdata = dma_data_in[DMA_DATA_W-1:BYTE_W];
        else
          next_rdata = dma_data_in[BYTE_W-1:0];
      end
      if (stretch_stop)
        next_stop_seen = 1'b1;
    end
  end

  // dma bus address and write data drive
  always_comb
  begin
    next_dma_addr = dma_addr;
    next_dma_addr_oe = 1'b0;
    next_dma_data = dma_data_out;
    next_dma_oe = 2'b00;
    if (granted)
    begin
      next_dma_addr = cpu.addr[BUF_ADDR_W-1:0];
      next_dma_addr_oe = 1'b1;
      if (!cpu.read)
      begin
        // a processor write drives only the byte lane it targets
        if (upper_lane)
        begin
          next_dma_data = {cpu.wdata, {BYTE_W{1'b0}}};
          next_dma_oe = 2'b10;
        end
        else
        begin
          next_dma_data = {{BYTE_W{1'b0}}, cpu.wdata};
          next_dma_oe = 2'b01;
        end
      end
    end
  end

  // strobes and chip selects follow the address and strobe phases
  always_comb
  begin
    next_rd_n = 1'b1;
    next_wr_n = 1'b1;
    next_cs_host_n = 1'b1;
    next_cs_lo_n = 1'b1;
    next_cs_hi_n = 1'b1;
    if (granted)
    begin
      // the disc data controller decodes its own select
      next_cs_host_n = !(target == TGT_HOST_IF);
      next_cs_lo_n = !(target == TGT_BUF_LO);
      next_cs_hi_n = !(target == TGT_BUF_HI);
      // strobe stays down until the stop so the device sees one edge
      if (strobe_phase && !stretch_stop)
      begin
        next_rd_n = !cpu.read;
        next_wr_n = cpu.read;
      end
    end
  end

  // transceiver enables
  always_comb
  begin
    next_bridge_n = 1'b1;
    next_upper_n = 1'b1;
    // bridge opens only for a granted processor dma access, never for local
    if (granted && dma_access)
      next_bridge_n = 1'b0;
    if (local_dma_active)
      next_upper_n = 1'b0;
    else if (granted)
      next_upper_n = !upper_lane;
    else if (remote_dma_active)
      next_upper_n = !remote_upper_sel;
  end

  // control bit register
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ctrl_bits <= CTRL_RESET;
    else
      ctrl_bits <= next_ctrl;
  end

  // processor read data and its guard against captures after the stop
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cpu_rdata <= '0;
      cpu_rdata_oe <= 1'b0;
      stop_seen <= 1'b0;
    end
    else
    begin
      cpu_rdata <= next_rdata;
      cpu_rdata_oe <= next_rdata_oe;
      stop_seen <= next_stop_seen;
    end
  end

  // dma bus address and write data, released out of reset
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      dma_addr <= '0;
      dma_addr_oe <= 1'b0;
      dma_data_out <= '0;
      dma_data_oe <= 2'b00;
    end
    else
    begin
      dma_addr <= next_dma_addr;
      dma_addr_oe <= next_dma_addr_oe;
      dma_data_out <= next_dma_data;
      dma_data_oe <= next_dma_oe;
    end
  end

  // strobes and selects idle high so reset never touches a device
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      dma_read_strobe_n <= 1'b1;
      dma_write_strobe_n <= 1'b1;
      cs_host_if_n <= 1'b1;
      cs_buf_lo_n <= 1'b1;
      cs_buf_hi_n <= 1'b1;
    end
    else
    begin
      dma_read_strobe_n <= next_rd_n;
      dma_write_strobe_n <= next_wr_n;
      cs_host_if_n <= next_cs_host_n;
      cs_buf_lo_n <= next_cs_lo_n;
      cs_buf_hi_n <= next_cs_hi_n;
    end
  end

  // transceiver enables, both shut out of reset
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      bridge_xcvr_enable_n <= 1'b1;
      upper_xcvr_enable_n <= 1'b1;
    end
    else
    begin
      bridge_xcvr_enable_n <= next_bridge_n;
      upper_xcvr_enable_n <= next_upper_n;
    end
  end
endmodule

// ### rtl/stretcher_pkg.sv
// shared constants, types and decode for the processor dma bus access stretcher
package stretcher_pkg;

  // processor clock generation
  localparam int CLK_IN_HZ = 12_000_000;
  localparam int CPU_CLK_DIV = 4;
  localparam int CPU_CLK_HZ = CLK_IN_HZ / CPU_CLK_DIV;

  // access sequence spacing in input clock periods
  localparam int ADDR_TO_STROBE = 2;
  localparam int STROBE_TO_STOP = 4;
  localparam int SEQ_CNT_W = 3;

  // bus widths
  localparam int CPU_ADDR_W = 16;
  localparam int BYTE_W = 8;
  localparam int BUF_ADDR_W = 13;
  localparam int DMA_DATA_W = 16;

  // processor address map, selected by the top nibble, buffers by the top three bits
  localparam logic [3:0] PAGE_REGS = 4'h1;
  localparam logic [3:0] PAGE_HOST_IF = 4'h2;
  localparam logic [3:0] PAGE_DDC = 4'h3;
  localparam logic [2:0] PAGE_BUF_LO = 3'h2;
  localparam logic [2:0] PAGE_BUF_HI = 3'h3;
  localparam int REG_SEL_BIT = 0;

  // control bit register fields
  localparam int CTRL_HEAD_LSB = 0;
  localparam int CTRL_HEAD_W = 3;
  localparam int CTRL_CMD_DATA = 3;
  localparam int CTRL_XFER_REQ = 4;
  localparam int CTRL_MEM_CLK = 5;
  localparam int CTRL_MEM_DATA = 6;
  localparam int CTRL_RG_DELAY = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // clock state machine, gray along s0-s1-s2-s3, stretch one step from s3
  typedef enum logic [2:0] {
    CK_S0 = 3'b000,
    CK_S1 = 3'b001,
    CK_S2 = 3'b011,
    CK_S3 = 3'b010,
    CK_STRETCH = 3'b110
  } clk_state_t;

  typedef enum logic [2:0] {
    TGT_NONE,
    TGT_REGS,
    TGT_HOST_IF,
    TGT_DDC,
    TGT_BUF_LO,
    TGT_BUF_HI
  } target_t;

  typedef struct packed {
    logic [CPU_ADDR_W-1:0] addr;
    logic read;
    logic [BYTE_W-1:0] wdata;
  } cpu_access_t;

  typedef struct packed {
    logic cfg_status;
    logic attention;
    logic xfer_ack;
    logic ready;
    logic sector;
    logic index;
  } drive_status_t;

  // maps a processor address onto the device it selects
  function automatic target_t decode_target(input logic [CPU_ADDR_W-1:0] a);
    target_t t;
    t = TGT_NONE;
    if (a[15:12] == PAGE_REGS)
      t = TGT_REGS;
    else if (a[15:12] == PAGE_HOST_IF)
      t = TGT_HOST_IF;
    else if (a[15:12] == PAGE_DDC)
      t = TGT_DDC;
    else if (a[15:13] == PAGE_BUF_LO)
      t = TGT_BUF_LO;
    else if (a[15:13] == PAGE_BUF_HI)
      t = TGT_BUF_HI;
    return t;
  endfunction

  function automatic logic on_dma_bus(input target_t t);
    return (t == TGT_HOST_IF) || (t == TGT_DDC) || (t == TGT_BUF_LO) || (t == TGT_BUF_HI);
  endfunction

endpackage

// ### testbench/cpu_dma_bus_access_stretcher_monitor.sv
// port assertions for the processor dma bus access stretcher
`timescale 1ns/1ns
module cpu_dma_bus_access_stretcher_monitor
  import stretcher_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // watched ports
  input wire stretcher_pkg::cpu_access_t cpu,
  input wire logic cpu_clk_a,
  input wire logic cpu_clk_b,
  input wire logic cpu_bus_request_n,
  input wire logic cpu_grant_active,
  input wire logic local_dma_active,
  input wire logic [1:0] dma_data_oe,
  input wire logic dma_read_strobe_n,
  input wire logic dma_write_strobe_n,
  input wire logic cs_host_if_n,
  input wire logic cs_buf_lo_n,
  input wire logic cs_buf_hi_n,
  input wire logic bridge_xcvr_enable_n,
  input wire logic upper_xcvr_enable_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic strb;
  // high while neither strobe is driven low
  assign strb = dma_read_strobe_n & dma_write_strobe_n;
  sequence s_addr_wait;
    strb [*2];
  endsequence
  sequence s_strobe_low;
    !strb [*4];
  endsequence
  property p_div4;
    $fell(cpu_clk_a) |-> !cpu_clk_b ##1 (cpu_clk_b && !cpu_clk_a) ##1 (cpu_clk_a && cpu_clk_b);
  endproperty
  a_div4: assert property (p_div4) else $error("clock a/b sequence wrong");
  property p_hold;
    !cpu_bus_request_n |-> cpu_clk_a && !cpu_clk_b;
  endproperty
  a_hold: assert property (p_hold) else $error("clocks not held in stretch");
  property p_enter;
    $fell(cpu_bus_request_n) |-> cpu.addr[15:13] inside {3'h1, 3'h2, 3'h3};
  endproperty
  a_enter: assert property (p_enter) else $error("stretch for non dma address");
  // whole access: address phase, two quiet cycles, four strobe cycles, then release
  property p_seq;
    $fell(bridge_xcvr_enable_n) |-> s_addr_wait ##1 s_strobe_low
      ##1 (strb && $rose(cpu_bus_request_n) && !cpu_clk_a);
  endproperty
  a_seq: assert property (p_seq) else $error("access sequence timing wrong");
  property p_byte;
    dma_data_oe != 2'h3;
  endproperty
  a_byte: assert property (p_byte) else $error("both lanes driven");
  property p_upper_on;
    !cs_buf_hi_n |-> !upper_xcvr_enable_n;
  endproperty
  a_upper_on: assert property (p_upper_on) else $error("upper lane shut");
  property p_upper_off;
    (!cs_buf_lo_n || !cs_host_if_n) |-> upper_xcvr_enable_n;
  endproperty
  a_upper_off: assert property (p_upper_off) else $error("upper lane open");
  property p_bridge;
    !bridge_xcvr_enable_n |->
      cpu_grant_active || $past(cpu_grant_active) || $past(cpu_grant_active, 2);
  endproperty
  a_bridge: assert property (p_bridge) else $error("bridge open without grant");
  property p_local;
    local_dma_active && $past(local_dma_active) |-> bridge_xcvr_enable_n && !upper_xcvr_enable_n;
  endproperty
  a_local: assert property (p_local) else $error("lanes wrong in local transfer");
  property p_release;
    $fell(cpu_grant_active) |->
      ##2 (bridge_xcvr_enable_n && cs_buf_lo_n && cs_buf_hi_n && cs_host_if_n);
  endproperty
  a_release: assert property (p_release) else $error("selects kept after grant");
  property p_reset;
    $fell(rst) |-> cpu_bus_request_n && strb && bridge_xcvr_enable_n && upper_xcvr_enable_n
      && !cpu_clk_a && !cpu_clk_b && dma_data_oe == 2'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("not idle after reset");
endmodule

bind cpu_dma_bus_access_stretcher cpu_dma_bus_access_stretcher_monitor mon (.clk_sys, .rst,
  .cpu, .cpu_clk_a, .cpu_clk_b, .cpu_bus_request_n, .cpu_grant_active, .local_dma_active,
  .dma_data_oe, .dma_read_strobe_n, .dma_write_strobe_n, .cs_host_if_n, .cs_buf_lo_n,
  .cs_buf_hi_n, .bridge_xcvr_enable_n, .upper_xcvr_enable_n);

// ### testbench/cpu_dma_bus_access_stretcher_test.sv
// self-checking bench for the processor dma bus access stretcher
`timescale 1ns/1ns
module cpu_dma_bus_access_stretcher_test;
  import stretcher_pkg::*;
  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] exp;
    logic str;
    logic [7:0] gd;
  } row_t;
  logic clk_sys, rst, cpu_clk_a, cpu_clk_b, cpu_bus_request_n, cpu_grant_active;
  logic local_dma_active, remote_dma_active, remote_upper_sel;
  logic dma_read_strobe_n, dma_write_strobe_n, cs_host_if_n, cs_buf_lo_n, cs_buf_hi_n;
  logic bridge_xcvr_enable_n, upper_xcvr_enable_n, cpu_rdata_oe, dma_addr_oe;
  logic [7:0] cpu_rdata, ctrl_bits, gdly;
  logic [12:0] dma_addr;
  logic [15:0] dma_data_in, dma_data_out;
  cpu_access_t cpu;
  drive_status_t drive_status;
  int miscompares = 0;
  int comparisons = 0;
  // writes, reads, boundaries and an unmapped page; grant wait varies
  row_t rows [12] = '{
    '{16'h1000, 1'b0, 8'hA5, 8'h00, 1'b0, 8'h00},
    '{16'h1000, 1'b0, 8'h18, 8'h00, 1'b0, 8'h00},
    '{16'h1001, 1'b1, 8'h00, 8'h2D, 1'b0, 8'h00},
    '{16'h4010, 1'b0, 8'h3C, 8'h00, 1'b1, 8'h00},
    '{16'h6010, 1'b0, 8'hC3, 8'h00, 1'b1, 8'h05},
    '{16'h4010, 1'b1, 8'h00, 8'h3C, 1'b1, 8'h00},
    '{16'h6010, 1'b1, 8'h00, 8'hC3, 1'b1, 8'h1F},
    '{16'h7FFF, 1'b0, 8'h7E, 8'h00, 1'b1, 8'h01},
    '{16'h7FFF, 1'b1, 8'h00, 8'h7E, 1'b1, 8'h02},
    '{16'h2005, 1'b0, 8'h5A, 8'h00, 1'b1, 8'h03},
    '{16'h3000, 1'b0, 8'h77, 8'h00, 1'b1, 8'h00},
    '{16'h8000, 1'b1, 8'h00, 8'h00, 1'b0, 8'h00}};

  cpu_dma_bus_access_stretcher dut (.clk_sys, .rst, .cpu, .cpu_clk_a, .cpu_clk_b, .cpu_rdata,
    .cpu_rdata_oe, .cpu_bus_request_n, .cpu_grant_active, .local_dma_active,
    .remote_dma_active, .remote_upper_sel, .dma_addr, .dma_addr_oe, .dma_data_in,
    .dma_data_out, .dma_data_oe(), .dma_read_strobe_n, .dma_write_strobe_n, .cs_host_if_n,
    .cs_buf_lo_n, .cs_buf_hi_n, .bridge_xcvr_enable_n, .upper_xcvr_enable_n, .drive_status,
    .ctrl_bits);
  dma_bus_partner far_end (.clk_sys, .rst, .cpu_bus_request_n, .grant_delay(gdly),
    .cpu_grant_active, .dma_addr, .dma_data_out, .dma_read_strobe_n, .dma_write_strobe_n,
    .cs_buf_lo_n, .cs_buf_hi_n, .dma_data_in);

  task automatic stop_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // outputs that must all be idle while reset is held
  task automatic idle_check;
    @(negedge clk_sys);
    check({6'h00, cpu_bus_request_n, bridge_xcvr_enable_n, upper_xcvr_enable_n,
      dma_read_strobe_n, dma_write_strobe_n, cs_host_if_n, cs_buf_lo_n, cs_buf_hi_n,
      cpu_clk_a, cpu_clk_b}, 16'h03FC);
    check(16'(ctrl_bits), 16'h0000);
  endtask

  // one processor cycle, address set as clock a falls
  task automatic access(input row_t r);
    int n;
    logic seen, a_was, drives;
    seen = 1'b0;
    a_was = 1'b0;
    // read data is driven only for reads of mapped registers or dma devices
    drives = r.rd && (r.str || r.addr[15:12] == 4'h1);
    gdly <= r.gd;
    @(negedge cpu_clk_a);
    cpu <= {r.addr, r.rd, r.wdata};
    for (n = 0; n < 400; n++)
    begin
      @(negedge clk_sys);
      if (!cpu_bus_request_n)
        seen = 1'b1;
      if (cpu_clk_a)
        a_was = 1'b1;
      else if (a_was)
        break;
    end
    check(16'(seen), 16'(r.str));
    check({14'h0, cpu_rdata_oe, dma_addr_oe}, {14'h0, drives, r.str});
    if (drives)
      check(16'(cpu_rdata), 16'(r.exp));
    if (!r.rd && r.addr[15:12] == 4'h1)
      check(16'(ctrl_bits), 16'(r.wdata));
    // idle address before the next sample point, else a second stretch starts
    @(posedge clk_sys);
    cpu <= 25'h0;
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial
  begin
    #400000;
    miscompares++;
    stop_test();
  end

  initial
  begin
    int n;
    time t1;
    rst = 1'b1;
    cpu = 25'h0;
    gdly = 8'h00;
    local_dma_active = 1'b0;
    remote_dma_active = 1'b0;
    remote_upper_sel = 1'b0;
    drive_status = 6'h2D;
    idle_check();
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge cpu_clk_a);
    t1 = $time;
    @(posedge cpu_clk_a);
    check(16'($time - t1), 16'h0050);
    foreach (rows[i])
      access(rows[i]);
    // local transfer keeps the bridge shut and opens both lanes
    @(posedge clk_sys);
    local_dma_active <= 1'b1;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check({14'h0, bridge_xcvr_enable_n, upper_xcvr_enable_n}, 16'h0002);
    @(posedge clk_sys);
    local_dma_active <= 1'b0;
    for (n = 0; n < 2; n++)
    begin
      remote_dma_active <= 1'b1;
      remote_upper_sel <= n[0];
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      check(16'(upper_xcvr_enable_n), 16'(!n[0]));
      @(posedge clk_sys);
    end
    remote_dma_active <= 1'b0;
    // reset in mid stretch while a slow grant is pending
    gdly <= 8'h60;
    @(negedge cpu_clk_a);
    cpu <= {16'h4020, 1'b0, 8'h11};
    for (n = 0; n < 100 && cpu_bus_request_n; n++)
      @(negedge clk_sys);
    check(16'(cpu_bus_request_n), 16'h0000);
    @(posedge clk_sys);
    rst <= 1'b1;
    cpu <= 25'h0;
    repeat (2) @(posedge clk_sys);
    idle_check();
    @(posedge clk_sys);
    rst <= 1'b0;
    access(rows[4]);
    stop_test();
  end
endmodule

// ### testbench/dma_bus_partner.sv
// arbiter and buffer rams on the far side of the dma bus
`timescale 1ns/1ns
module dma_bus_partner
  import stretcher_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // arbiter handshake
  input wire logic cpu_bus_request_n,
  input wire logic [7:0] grant_delay,
  output logic cpu_grant_active,
  // dma bus
  input wire logic [stretcher_pkg::BUF_ADDR_W-1:0] dma_addr,
  input wire logic [stretcher_pkg::DMA_DATA_W-1:0] dma_data_out,
  input wire logic dma_read_strobe_n,
  input wire logic dma_write_strobe_n,
  input wire logic cs_buf_lo_n,
  input wire logic cs_buf_hi_n,
  output logic [stretcher_pkg::DMA_DATA_W-1:0] dma_data_in
);
  logic [7:0] buf_lo [8192];
  logic [7:0] buf_hi [8192];
  logic [7:0] wait_cnt;
  logic [DMA_DATA_W-1:0] last;
  // grant after a set wait, held until the request is released
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cpu_grant_active <= 1'b0;
      wait_cnt <= 8'h00;
      last <= 16'h0000;
    end
    else
    begin
      last <= dma_data_in;
      if (cpu_bus_request_n)
      begin
        cpu_grant_active <= 1'b0;
        wait_cnt <= 8'h00;
      end
      else if (wait_cnt == grant_delay)
        cpu_grant_active <= 1'b1;
      else
        wait_cnt <= wait_cnt + 8'h01;
    end
  end
  // byte wide buffers, lower on the low lane, upper on the high lane
  always_ff @(posedge clk_sys)
  begin
    if (!dma_write_strobe_n && !cs_buf_lo_n)
      buf_lo[dma_addr] <= dma_data_out[7:0];
    if (!dma_write_strobe_n && !cs_buf_hi_n)
      buf_hi[dma_addr] <= dma_data_out[15:8];
  end
  // undriven lanes toggle so a stale byte never passes for a read
  always_comb
  begin
    dma_data_in = ~last;
    if (!dma_read_strobe_n && !cs_buf_lo_n)
      dma_data_in[7:0] = buf_lo[dma_addr];
    if (!dma_read_strobe_n && !cs_buf_hi_n)
      dma_data_in[15:8] = buf_hi[dma_addr];
  end
endmodule
